// ---- hw/fuse_config_loader.sv ----
// reset-time fuse loader distributing configuration fields to peripherals
`default_nettype none
`include "fuse_config_loader_regs.svh"
// Overview of operation
// - watchdog window gets upper fuse nibble
// - watchdog period gets lower fuse nibble
// - brown-out settings reload only after power-on
// - three-bit threshold level copied to brown-out
// - sampling-rate bit loaded: 0 fast, 1 slow
// - active brown-out mode loaded, four codes
// - sleep brown-out mode loaded, code three reserved; the code loads it as bod_on_wait
// - oscillator lock bit copied to calibration
// - frequency select picks matching factory trims
// - memory scan source encoded four ways
// - shared pin function selected, code three reserved
// - chip erase keeps eeprom if preserve bit set, unless locked
// - startup code sets delay before execution
// - application end marks code boundary blocks
// - zero application end: code to flash top
// - boot end marks boot; zero means all
module fuse_config_loader
    import fuse_config_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = (`CLK_FREQ_HZ / `MS_PER_S) * `STARTUP_STEP_MS,
    parameter int unsigned FLASH_BYTES = 16384,
    parameter int unsigned CAL_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic por_b_i,
    // fuse array read port
    output logic [3:0] nvm_addr_o,
    output logic nvm_read_o,
    input wire logic [7:0] nvm_data_i,
    input wire logic nvm_valid_i,
    // factory calibration values
    input wire logic [CAL_W-1:0] factory_trim16_i,
    input wire logic [CAL_W-1:0] factory_trim20_i,
    input wire logic [CAL_W-1:0] factory_temp16_i,
    input wire logic [CAL_W-1:0] factory_temp20_i,
    input wire logic device_locked_i,
    // watchdog
    output logic [3:0] wdt_window_o,
    output logic [3:0] wdt_period_o,
    // brown-out detector
    output logic [2:0] bod_level_o,
    output logic bod_sampling_rate_bit_o,
    output bod_mode_type bod_active_mode_o,
    output bod_mode_type bod_sleep_mode_o,
    // clock controller
    output logic calibration_lock_bit_o,
    output freq_select_type frequency_select_o,
    output logic [CAL_W-1:0] oscillator_trim_field_o,
    output logic [CAL_W-1:0] oscillator_temperature_trim_o,
    // system
    output scan_source_type memory_scan_source_o,
    output pin_function_type reset_pin_function_o,
    output logic chip_erase_o,
    output logic eeprom_erase_o,
    output logic cpu_release_o,
    // flash partition
    output logic [`LIMIT_W-1:0] boot_limit_o,
    output logic [`LIMIT_W-1:0] app_limit_o,
    input wire logic [`LIMIT_W-1:0] flash_probe_addr_i,
    output flash_region_type flash_region_o,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    // ------------------------------------------------------------------
    // fetch sequencing
    // ------------------------------------------------------------------
    loader_state_type state;
    logic [2:0] slot;
    logic [7:0] shadow [`SLOT_COUNT];
    logic por_pending;
    logic por_loaded;
    logic [31:0] cyc_count;
    logic [6:0] ms_count;
    logic [6:0] ms_target;
    logic [`LIMIT_W-1:0] flash_top;
    logic bus_ack;
    logic bus_req;
    logic [5:0] bus_index;
    assign flash_top = `LIMIT_W'(FLASH_BYTES);
    // slots from the system byte on step over the two reserved fuse offsets
    assign nvm_addr_o = (slot < `SLOT_SYS0) ? {1'b0, slot} : {1'b0, slot} + `FUSE_SKIP;
    // read request held through every slot until the array answers the last one
    assign nvm_read_o = (state == st_read);
    // walk the fuse bytes, then apply, wait out the startup delay, release
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= st_read;
            slot <= `SLOT_WDT;
        end else begin
            unique case (state)
                st_read: begin
                    if (nvm_valid_i) begin
                        if (slot == `SLOT_LAST) begin
                            state <= st_apply;
                        end else begin
                            slot <= slot + 3'h1;
                        end
                    end
                end
                st_apply: begin
                    state <= st_delay;
                end
                st_delay: begin
                    if (ms_count == ms_target) begin
                        state <= st_run;
                    end
                end
                st_run: begin
                    state <= st_run;
                end
            endcase
        end
    end
    // capture each fuse byte; defaults mirror the unprogrammed fuse values
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shadow[`SLOT_WDT] <= `ZERO_BYTE;
            shadow[`SLOT_BOD] <= `ZERO_BYTE;
            shadow[`SLOT_OSC] <= `OSC_RESET;
            shadow[`SLOT_SYS0] <= `SYS0_RESET;
            shadow[`SLOT_SYS1] <= `SYS1_RESET;
            shadow[`SLOT_APP] <= `ZERO_BYTE;
            shadow[`SLOT_BOOT] <= `ZERO_BYTE;
        end else if (state == st_read && nvm_valid_i) begin
            shadow[slot] <= nvm_data_i;
        end
    end
    // ------------------------------------------------------------------
    // startup delay
    // ------------------------------------------------------------------
    // code 0 gives no delay, code n gives 2^(n-1) milliseconds
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ms_target <= 7'h00;
        end else if (state == st_apply) begin
            if (shadow[`SLOT_SYS1][`SYS_SUT_RANGE] == 3'h0) begin
                ms_target <= 7'h00;
            end else begin
                ms_target <= 7'h01 << (shadow[`SLOT_SYS1][`SYS_SUT_RANGE] - 3'h1);
            end
        end
    end
    // millisecond prescaler; a full count is kept as a parameter for fast sims
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cyc_count <= 32'h0000_0000;
            ms_count <= 7'h00;
        end else if (state == st_delay && ms_count != ms_target) begin
            if (cyc_count == 32'(STEP_CYCLES - 1)) begin
                cyc_count <= 32'h0000_0000;
                ms_count <= ms_count + 7'h01;
            end else begin
                cyc_count <= cyc_count + 32'h0000_0001;
            end
        end
    end
    // processor stays in reset until every field is out and the delay is over
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cpu_release_o <= 1'b0;
        end else begin
            cpu_release_o <= (state == st_run);
        end
    end
    // ------------------------------------------------------------------
    // distribution on every system reset
    // ------------------------------------------------------------------
    // watchdog, clock and system fields; held until the next reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wdt_window_o <= 4'h0;
            wdt_period_o <= 4'h0;
            memory_scan_source_o <= scan_full_flash;
            reset_pin_function_o <= pin_gpio;
            calibration_lock_bit_o <= 1'b0;
            frequency_select_o <= freq_res0;
        end else if (state == st_apply) begin
            wdt_window_o <= shadow[`SLOT_WDT][`WDT_WINDOW_RANGE];
            wdt_period_o <= shadow[`SLOT_WDT][`WDT_PERIOD_RANGE];
            memory_scan_source_o <=
                scan_source_type'(shadow[`SLOT_SYS0][`SYS_SCAN_RANGE]);
            reset_pin_function_o <=
                pin_function_type'(shadow[`SLOT_SYS0][`SYS_PIN_RANGE]);
            calibration_lock_bit_o <= shadow[`SLOT_OSC][`OSC_LOCK_BIT];
            frequency_select_o <= freq_select_type'(shadow[`SLOT_OSC][`OSC_FREQ_RANGE]);
        end
    end
    // factory trims follow the frequency; reserved codes fall back to the faster set
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            oscillator_trim_field_o <= '0;
            oscillator_temperature_trim_o <= '0;
        end else if (state == st_apply) begin
            if (shadow[`SLOT_OSC][`OSC_FREQ_RANGE] == freq_16) begin
                oscillator_trim_field_o <= factory_trim16_i;
                oscillator_temperature_trim_o <= factory_temp16_i;
            end else begin
                oscillator_trim_field_o <= factory_trim20_i;
                oscillator_temperature_trim_o <= factory_temp20_i;
            end
        end
    end
    // ------------------------------------------------------------------
    // brown-out settings, power-on domain
    // ------------------------------------------------------------------
    // these sit on the power-on reset only, so a system reset cannot disturb them
    always_ff @(posedge clk_i or negedge por_b_i) begin
        if (!por_b_i) begin
            por_pending <= 1'b1;
            por_loaded <= 1'b0;
        end else if (state == st_apply && por_pending) begin
            por_pending <= 1'b0;
            por_loaded <= 1'b1;
        end
    end
    // reload only on the first apply after power-on
    always_ff @(posedge clk_i or negedge por_b_i) begin
        if (!por_b_i) begin
            bod_level_o <= 3'h0;
            bod_sampling_rate_bit_o <= 1'b0;
            bod_active_mode_o <= bod_off;
            bod_sleep_mode_o <= bod_off;
        end else if (state == st_apply && por_pending) begin
            bod_level_o <= shadow[`SLOT_BOD][`BOD_LEVEL_RANGE];
            bod_sampling_rate_bit_o <= shadow[`SLOT_BOD][`BOD_SAMP_BIT];
            bod_active_mode_o <= bod_mode_type'(shadow[`SLOT_BOD][`BOD_ACTIVE_RANGE]);
            bod_sleep_mode_o <= bod_mode_type'(shadow[`SLOT_BOD][`BOD_SLEEP_RANGE]);
        end
    end
    // ------------------------------------------------------------------
    // flash partition
    // ------------------------------------------------------------------
    // boundaries in bytes; a zero boot end turns the whole flash into boot
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            boot_limit_o <= '0;
            app_limit_o <= '0;
        end else if (state == st_apply) begin
            if (shadow[`SLOT_BOOT] == `ZERO_BYTE) begin
                boot_limit_o <= flash_top;
            end else begin
                boot_limit_o <= `LIMIT_W'({shadow[`SLOT_BOOT], `BLOCK_PAD});
            end
            if (shadow[`SLOT_APP] == `ZERO_BYTE) begin
                app_limit_o <= flash_top;
            end else begin
                app_limit_o <= `LIMIT_W'({shadow[`SLOT_APP], `BLOCK_PAD});
            end
        end
    end
    // classify an address; application end below boot end leaves no code section
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flash_region_o <= region_boot;
        end else if (flash_probe_addr_i < boot_limit_o) begin
            flash_region_o <= region_boot;
        end else if (flash_probe_addr_i < app_limit_o) begin
            flash_region_o <= region_app_code;
        end else begin
            flash_region_o <= region_app_data;
        end
    end

    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    // one wait state per access; the second edge completes it
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_index = avs_address_i[`REG_INDEX_RANGE];
    assign avs_waitrequest_o = bus_req & ~bus_ack;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    // read data registered in the wait cycle; unmapped words read zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !bus_ack) begin
            avs_readdata_o <= 32'h0000_0000;
            unique case (bus_index)
                6'(`FUSE_WDT_OFS): avs_readdata_o[7:0] <= shadow[`SLOT_WDT];
                6'(`FUSE_BOD_OFS): avs_readdata_o[7:0] <= shadow[`SLOT_BOD];
                6'(`FUSE_OSC_OFS): avs_readdata_o[7:0] <= shadow[`SLOT_OSC];
                6'(`FUSE_SYS0_OFS): avs_readdata_o[7:0] <= shadow[`SLOT_SYS0];
                6'(`FUSE_SYS1_OFS): avs_readdata_o[7:0] <= shadow[`SLOT_SYS1];
                6'(`FUSE_APP_OFS): avs_readdata_o[7:0] <= shadow[`SLOT_APP];
                6'(`FUSE_BOOT_OFS): avs_readdata_o[7:0] <= shadow[`SLOT_BOOT];
                `REG_STATUS_IDX: begin
                    avs_readdata_o[`STATUS_LOADED_BIT] <= (state == st_delay) ||
                                                         (state == st_run);
                    avs_readdata_o[`STATUS_RUN_BIT] <= cpu_release_o;
                    avs_readdata_o[`STATUS_POR_BIT] <= por_loaded;
                    avs_readdata_o[`STATUS_LOCKED_BIT] <= device_locked_i;
                end
                default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // erase command: a locked part always loses the eeprom
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            chip_erase_o <= 1'b0;
            eeprom_erase_o <= 1'b0;
        end else begin
            chip_erase_o <= 1'b0;
            eeprom_erase_o <= 1'b0;
            if (avs_write_i && bus_ack && bus_index == `REG_CONTROL_IDX &&
                avs_byteenable_i[0] && avs_writedata_i[`CONTROL_ERASE_BIT]) begin
                chip_erase_o <= 1'b1;
                eeprom_erase_o <= device_locked_i ||
                                  !shadow[`SLOT_SYS0][`SYS_EEPROM_PRESERVE_BIT_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_window;
        @(posedge clk_i) disable iff (!rst_b_i)
        cpu_release_o |-> wdt_window_o == shadow[`SLOT_WDT][`WDT_WINDOW_RANGE];
    endproperty
    a_window: assert property (p_window) else $error("watchdog window mismatch");
    property p_period;
        @(posedge clk_i) disable iff (!rst_b_i)
        state == st_apply |=> wdt_period_o == shadow[`SLOT_WDT][`WDT_PERIOD_RANGE];
    endproperty
    a_period: assert property (p_period) else $error("watchdog period mismatch");
    property p_bod_hold;
        @(posedge clk_i) disable iff (!por_b_i)
        !por_pending |=> $stable(bod_level_o) && $stable(bod_active_mode_o);
    endproperty
    a_bod_hold: assert property (p_bod_hold) else $error("brown-out changed");
    property p_bod_level;
        @(posedge clk_i) disable iff (!por_b_i || !rst_b_i)
        state == st_apply && por_pending |=>
            bod_level_o == shadow[`SLOT_BOD][`BOD_LEVEL_RANGE] &&
            bod_sampling_rate_bit_o == shadow[`SLOT_BOD][`BOD_SAMP_BIT];
    endproperty
    a_bod_level: assert property (p_bod_level) else $error("brown-out not loaded");
    property p_lock;
        @(posedge clk_i) disable iff (!rst_b_i)
        cpu_release_o |-> calibration_lock_bit_o == shadow[`SLOT_OSC][`OSC_LOCK_BIT];
    endproperty
    a_lock: assert property (p_lock) else $error("lock bit mismatch");
    property p_trim16;
        @(posedge clk_i) disable iff (!rst_b_i)
        state == st_apply && shadow[`SLOT_OSC][`OSC_FREQ_RANGE] == freq_16 |=>
            oscillator_trim_field_o == $past(factory_trim16_i);
    endproperty
    a_trim16: assert property (p_trim16) else $error("wrong trim set");
    property p_erase_locked;
        @(posedge clk_i) disable iff (!rst_b_i)
        chip_erase_o && $past(device_locked_i) |-> eeprom_erase_o;
    endproperty
    a_erase_locked: assert property (p_erase_locked) else $error("eeprom kept");
    property p_no_delay;
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(state == st_delay) && ms_target == 7'h00 |-> ##[1:2] cpu_release_o;
    endproperty
    a_no_delay: assert property (p_no_delay) else $error("release late");
    property p_boot_all;
        @(posedge clk_i) disable iff (!rst_b_i)
        state == st_apply && shadow[`SLOT_BOOT] == `ZERO_BYTE |=> boot_limit_o == flash_top;
    endproperty
    a_boot_all: assert property (p_boot_all) else $error("boot limit wrong");
    property p_release_stable;
        @(posedge clk_i) disable iff (!rst_b_i)
        cpu_release_o |=> cpu_release_o && $stable(wdt_window_o) && $stable(app_limit_o);
    endproperty
    a_release_stable: assert property (p_release_stable) else $error("unstable");
endmodule // fuse_config_loader
`default_nettype wire

// ---- hw/fuse_config_loader_regs.svh ----
// constants of the fuse configuration loader: offsets, fields, reset values, timing
`ifndef FUSE_CONFIG_LOADER_REGS_SVH
`define FUSE_CONFIG_LOADER_REGS_SVH
// fuse array offsets
`define FUSE_WDT_OFS 4'h0
`define FUSE_BOD_OFS 4'h1
`define FUSE_OSC_OFS 4'h2
`define FUSE_SYS0_OFS 4'h5
`define FUSE_SYS1_OFS 4'h6
`define FUSE_APP_OFS 4'h7
`define FUSE_BOOT_OFS 4'h8
// distance over the two reserved fuse offsets behind the oscillator byte
`define FUSE_SKIP 4'h2
// shadow slots, one per fuse byte
`define SLOT_WDT 3'h0
`define SLOT_BOD 3'h1
`define SLOT_OSC 3'h2
`define SLOT_SYS0 3'h3
`define SLOT_SYS1 3'h4
`define SLOT_APP 3'h5
`define SLOT_BOOT 3'h6
`define SLOT_LAST 3'h6
`define SLOT_COUNT 7
// field positions
`define WDT_WINDOW_RANGE 7:4
`define WDT_PERIOD_RANGE 3:0
`define BOD_LEVEL_RANGE 7:5
`define BOD_SAMP_BIT 4
`define BOD_ACTIVE_RANGE 3:2
`define BOD_SLEEP_RANGE 1:0
`define OSC_LOCK_BIT 7
`define OSC_FREQ_RANGE 1:0
`define SYS_SCAN_RANGE 7:6
`define SYS_PIN_RANGE 3:2
`define SYS_EEPROM_PRESERVE_BIT_BIT 0
`define SYS_SUT_RANGE 2:0
// shadow reset values
`define ZERO_BYTE 8'h00
`define OSC_RESET 8'h02
`define SYS0_RESET 8'hc4
`define SYS1_RESET 8'h07
// register indices of the bus map; byte address is four times the index
`define REG_INDEX_RANGE 7:2
`define REG_STATUS_IDX 6'h10
`define REG_CONTROL_IDX 6'h11
`define STATUS_LOADED_BIT 0
`define STATUS_RUN_BIT 1
`define STATUS_POR_BIT 2
`define STATUS_LOCKED_BIT 3
`define CONTROL_ERASE_BIT 0
// flash partition: blocks of 256 bytes
`define BLOCK_PAD 8'h00
`define LIMIT_W 17
// timing
`define CLK_FREQ_HZ 50000000
`define STARTUP_STEP_MS 1
`define MS_PER_S 1000
`endif

// ---- hw/fuse_config_pkg.sv ----
// types shared by the fuse configuration loader
`default_nettype none
package fuse_config_pkg;
    typedef enum logic [1:0] {
        st_read = 2'b00, st_apply = 2'b01, st_delay = 2'b10, st_run = 2'b11
    } loader_state_type;
    typedef enum logic [1:0] {
        scan_full_flash = 2'b00, scan_boot = 2'b01,
        boot_plus_application_scan = 2'b10, scan_disabled = 2'b11
    } scan_source_type;
    typedef enum logic [1:0] {
        pin_gpio = 2'b00, pin_debug = 2'b01, pin_reset = 2'b10, pin_reserved = 2'b11
    } pin_function_type;
    typedef enum logic [1:0] {
        bod_off = 2'b00, bod_on = 2'b01, bod_sampled = 2'b10, bod_on_wait = 2'b11
    } bod_mode_type;
    typedef enum logic [1:0] {
        freq_res0 = 2'b00, freq_16 = 2'b01, freq_20 = 2'b10, freq_res3 = 2'b11
    } freq_select_type;
    typedef enum logic [1:0] {
        region_boot = 2'b00, region_app_code = 2'b01, region_app_data = 2'b10
    } flash_region_type;
endpackage : fuse_config_pkg
`default_nettype wire

// ---- verif/fuse_array_model.sv ----
// behavioural fuse array answering the loader's fetch port
`default_nettype none
module fuse_array_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic slow_i,
    input wire logic read_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] fuse_i [9],
    output logic [7:0] data_o,
    output logic valid_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] lag;
    // one-cycle valid after one or three wait cycles, so both fast and slow arrays are seen
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            valid_o <= 1'b0;
            lag <= 2'h0;
        end else begin
            valid_o <= read_i && !valid_o && (!slow_i || lag == 2'h2);
            lag <= (valid_o || !read_i) ? 2'h0 : lag + 2'h1;
        end
    end
    // outside valid the data is inverted so a stale byte can never pass
    assign data_o = valid_o ? fuse_i[addr_i] : ~fuse_i[addr_i];
endmodule // fuse_array_model
`default_nettype wire

// ---- verif/fuse_config_loader_tb_top.sv ----
// self-checking bench of the fuse configuration loader
`default_nettype none
module fuse_config_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STEP = 4;
    logic clk_i = 0, rst_b_i = 0, por_b_i = 0, slow = 0, device_locked_i = 0, nvm_read_o;
    logic nvm_valid_i, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o, rel_d = 0;
    logic chip_erase_o, eeprom_erase_o, cpu_release_o, calibration_lock_bit_o, ee_exp;
    logic bod_sampling_rate_bit_o;
    logic [1:0] bod_active_mode_o, bod_sleep_mode_o, frequency_select_o, flash_region_o;
    logic [1:0] memory_scan_source_o, reset_pin_function_o;
    logic [2:0] bod_level_o;
    logic [3:0] nvm_addr_o, wdt_window_o, wdt_period_o, avs_byteenable_i = 4'hf;
    logic [7:0] nvm_data_i, avs_address_i = 0, bod_exp, f [9];
    logic [7:0] factory_trim16_i = 0, factory_trim20_i = 0, factory_temp16_i = 0;
    logic [7:0] factory_temp20_i = 0, oscillator_trim_field_o, oscillator_temperature_trim_o;
    logic [16:0] boot_limit_o, app_limit_o, flash_probe_addr_i = 0;
    logic [31:0] avs_writedata_i = 0, avs_readdata_o, e, exp_q [$];
    int failures = 0, n_tests = 0, cyc = 0, t0 = 0, rel_t = 0, n_erase = 0;
    fuse_config_loader #(.STEP_CYCLES(STEP)) fuse_config_loader_inst (.*);
    fuse_array_model fuse_array_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(slow),
        .read_i(nvm_read_o), .addr_i(nvm_addr_o), .fuse_i(f), .data_o(nvm_data_i),
        .valid_o(nvm_valid_i));
    always #10 clk_i = !clk_i;
    task automatic wrap_up;
        if (failures == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        n_tests++;
        if (s !== x) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask
    // ------------------------------------------------------------
    // monitor: bus answers, erase pulses, release timing, timeout
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        cyc++;
        if (avs_read_i && avs_waitrequest_o === 1'b0) begin
            e = exp_q.pop_front();
            chk("readdata", e, avs_readdata_o);
        end
        if (chip_erase_o === 1'b1) begin
            n_erase++;
            chk("eeprom erase", ee_exp, eeprom_erase_o);
        end
        if (nvm_read_o && nvm_valid_i && nvm_addr_o == 4'h8) t0 = cyc;
        if (cpu_release_o === 1'b1 && !rel_d) rel_t = cyc;
        rel_d <= cpu_release_o === 1'b1;
        if (cyc > 30000) begin
            failures++;
            wrap_up();
        end
    end
    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_read_i <= 0;
        avs_write_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        bus(0, a, 0);
    endtask
    function automatic logic [1:0] region_of(input logic [16:0] a);
        if (f[8] == 0 || a < f[8] * 256) return 2'b00;
        if (f[7] == 0) return 2'b01;
        return (a < f[7] * 256) ? 2'b01 : 2'b10;
    endfunction
    localparam logic [7:0] BA [6] = '{8'h00, 8'h08, 8'h14, 8'h18, 8'h1c, 8'h20};
    localparam int FI [6] = '{0, 2, 5, 6, 7, 8};
    logic [16:0] pa [5];
    initial begin
        void'($urandom(29));
        for (int r = 0; r < 8; r++) begin
            for (int i = 0; i < 9; i++) f[i] = 8'($urandom);
            f[6][2:0] = 3'(r);
            f[8] = (r == 2) ? 8'h00 : {3'h0, f[8][4:0]};
            f[7] = (r == 3) ? 8'h00 : f[8] + {4'h0, f[7][3:0]};
            {factory_trim16_i, factory_trim20_i, factory_temp16_i, factory_temp20_i} <= $urandom;
            slow <= r[0];
            device_locked_i <= r[1];
            if (r < 2 || r[2]) bod_exp = f[1];
            rst_b_i <= 0;
            por_b_i <= !(r < 2 || r[2]);
            repeat (10) @(posedge clk_i);
            rst_b_i <= 1;
            por_b_i <= 1;
            while (cpu_release_o !== 1'b1) @(posedge clk_i);
            @(posedge clk_i);
            chk("release", 4 + (r == 0 ? 0 : (1 << (r - 1)) * STEP), rel_t - t0);
            chk("window", f[0][7:4], wdt_window_o);
            chk("period", f[0][3:0], wdt_period_o);
            chk("bod", bod_exp, {bod_level_o, bod_sampling_rate_bit_o, bod_active_mode_o,
                bod_sleep_mode_o});
            chk("osc", {f[2][7], f[2][1:0], f[2][1:0] == 2'h1 ? {factory_trim16_i,
                factory_temp16_i} : {factory_trim20_i, factory_temp20_i}},
                {calibration_lock_bit_o, frequency_select_o, oscillator_trim_field_o,
                oscillator_temperature_trim_o});
            chk("sys", {f[5][7:6], f[5][3:2]}, {memory_scan_source_o,
                reset_pin_function_o});
            bus(1, 8'h00, 32'h0000_00ff);
            for (int i = 0; i < 6; i++) rd(BA[i], {24'h0, f[FI[i]]});
            rd(8'h30, 32'h0000_0000);
            rd(8'h40, {28'h0, r[1], 3'b111});
            ee_exp = r[1] | !f[5][0];
            bus(1, 8'h44, 32'h0000_0001);
            @(posedge clk_i); // the monitor counts the erase pulse at the edge before
            chk("erase count", r + 1, n_erase);
            pa = '{f[8] * 256, f[8] * 256 - 1, f[7] * 256, f[7] * 256 - 1, 17'($urandom) >> 3};
            for (int i = 0; i < 5; i++) begin
                pa[i] = pa[i] % 17'h0_4000; // a zero limit minus one would fall outside flash
                flash_probe_addr_i <= pa[i];
                repeat (2) @(posedge clk_i);
                chk("region", region_of(pa[i]), flash_region_o);
            end
        end
        wrap_up();
    end
endmodule // fuse_config_loader_tb_top
`default_nettype wire
